// ===== core/eeprom_defs.vh
// constants for the serial eeprom target logic
// assumes inclusion by the design file and the bench
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH
// select byte layout
// type code, value arbitrary
`define SEL_TYPE_ID 4'h6
`define SEL_DIR_READ 1'h1
// bit slot numbering
`define SLOT_ACK 4'h8
`define SLOT_LAST_DATA 4'h7
// parked count, wraps to zero on the clock fall that ends a start
`define SLOT_PRE_START 4'hF
`define BYTE_MSB 3'h7
// memory fill value as delivered
`define MEM_BLANK 8'hFF
// page size and write time
`define PAGE_BITS 4
`define WRITE_TIME_MS 5
`define CLK_MHZ 100
// write cycle count: 5 ms at 100 MHz, exact product
`define WRITE_CYCLES (`WRITE_TIME_MS * 1000 * `CLK_MHZ)
`endif

// ===== core/i2c_eeprom_slave.v
// i2c target of a small serial eeprom with page write and timed write cycle
// assumes scl and sda arrive from pins; sda is open drain outside
// memory resets blank; no registers reachable by software
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defs.vh"

// Operation
// - start is sda falling while scl high; watched except during write cycle
// - stop is sda rising while scl high; ends the communication
// - received bits are captured on scl rising edge
// - after 8 bits transmitter releases sda; receiver acks in ninth clock
// - select byte msb first: type id, three chip enables, direction bit
// - direction bit one means read, zero means write
// - matching select is acked in ninth slot; mismatch goes to standby
// - write: ack select, take word address, ack it, wait for data
// - write cycle starts only on stop right after a data byte ack
// - after write cycle, address points past last byte written
// - during write cycle sda released, all bus traffic ignored
// - inhibit high: select and address acked, data nacked, memory kept
// - page write takes 1 to 16 bytes, offset wraps inside page
// - reads behave the same whatever the inhibit level
// - after each output byte, master nack ends sending to standby
// - read right after start sends byte at counter, then increments
// - master ack gives next byte; counter wraps to zero after top
// - every memory byte reads ffh as delivered
// - device is always target, never drives scl
// - inhibit low or floating allows writes; floating enables are zero
// - array holds 128 or 256 bytes of 8 bits
// - byte and page write cycles finish within 5 ms
module i2c_eeprom_slave #(
  parameter ADDR_BITS = 8,
  parameter WRITE_CYCLES = `WRITE_CYCLES,
  parameter CNT_BITS = 20
) (
  input wire mclk_in,
  input wire rstn_in,
  input wire scl_in,
  input wire sda_in,
  input wire chip_sel_bit2_in,
  input wire chip_sel_bit1_in,
  input wire chip_sel_bit0_in,
  input wire write_inhibit_pin_in,
  input wire write_done_early_in,
  output reg sda_out,
  output reg sda_oe_out,
  output reg busy_out
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_SEL = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_WCYC = 3'h5;

  localparam MEM_DEPTH = 1 << ADDR_BITS;
  localparam PAGE_BUF = 1 << `PAGE_BITS;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg [2:0] ce_sync1_reg;
  reg [2:0] ce_sync2_reg;
  reg [2:0] ce_sync3_reg;
  reg [2:0] wi_sync_reg;
  reg scl_reg;
  reg sda_reg;
  reg [2:0] ce_reg;
  reg wi_reg;

  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      ce_sync1_reg <= 3'h0;
      ce_sync2_reg <= 3'h0;
      ce_sync3_reg <= 3'h0;
      wi_sync_reg <= 3'h0;
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
      ce_reg <= 3'h0;
      wi_reg <= 1'h0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      ce_sync1_reg <= {chip_sel_bit2_in, chip_sel_bit1_in, chip_sel_bit0_in};
      ce_sync2_reg <= ce_sync1_reg;
      ce_sync3_reg <= ce_sync2_reg;
      wi_sync_reg <= {wi_sync_reg[1:0], write_inhibit_pin_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_reg <= sda_sync_reg[2];
      if (ce_sync2_reg == ce_sync3_reg)
        ce_reg <= ce_sync3_reg;
      if (wi_sync_reg[1] == wi_sync_reg[2])
        wi_reg <= wi_sync_reg[2];
    end
  end

  // ****************************************************************
  // bus events
  // ****************************************************************
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;

  assign scl_rise = scl_reg & ~scl_d_reg;
  assign scl_fall = ~scl_reg & scl_d_reg;
  assign start_ev = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
  assign stop_ev = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;

  // ****************************************************************
  // memory and protocol
  // ****************************************************************
  reg [7:0] mem_reg [0:MEM_DEPTH-1];
  reg [7:0] page_data_reg [0:PAGE_BUF-1];
  reg [PAGE_BUF-1:0] page_mask_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [ADDR_BITS-1:0] addr_reg;
  reg [ADDR_BITS-1:0] last_addr_reg;
  reg ack_ok_reg;
  reg rd_dir_reg;
  reg data_seen_reg;
  reg [CNT_BITS-1:0] wcnt_reg;

  // ****************************************************************
  // decode functions
  // ****************************************************************
  function sel_match;
    input [7:0] sel;
    input [2:0] ce;
    begin
      sel_match = (sel[7:4] == `SEL_TYPE_ID) && (sel[3:1] == ce);
    end
  endfunction

  function [ADDR_BITS-1:0] page_next;
    input [ADDR_BITS-1:0] a;
    begin
      page_next = {a[ADDR_BITS-1:`PAGE_BITS],
        a[`PAGE_BITS-1:0] + {{(`PAGE_BITS-1){1'b0}}, 1'b1}};
    end
  endfunction

  integer i;
  genvar g;

  // ****************************************************************
  // memory array, flops so every byte resets blank
  // ****************************************************************
  generate
    for (g = 0; g < MEM_DEPTH; g = g + 1)
    begin : g_mem
      always @(posedge mclk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          mem_reg[g] <= `MEM_BLANK;
        else if (state_reg == ST_WCYC && wcnt_reg == {CNT_BITS{1'b0}}
          && page_mask_reg[g % PAGE_BUF] &&
          (g / PAGE_BUF) == (last_addr_reg >> `PAGE_BITS))
          mem_reg[g] <= page_data_reg[g % PAGE_BUF];
      end
    end
  endgenerate

  // ****************************************************************
  // main sequencer
  // ****************************************************************

  always @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= {ADDR_BITS{1'b0}};
      last_addr_reg <= {ADDR_BITS{1'b0}};
      ack_ok_reg <= 1'h0;
      rd_dir_reg <= 1'h0;
      data_seen_reg <= 1'h0;
      page_mask_reg <= {PAGE_BUF{1'b0}};
      wcnt_reg <= {CNT_BITS{1'b0}};
      sda_out <= 1'h0;
      sda_oe_out <= 1'h0;
      busy_out <= 1'h0;
      for (i = 0; i < PAGE_BUF; i = i + 1)
        page_data_reg[i] <= 8'h00;
    end
    else
    begin
      scl_d_reg <= scl_reg;
      sda_d_reg <= sda_reg;
      sda_out <= 1'h0;
      if (state_reg == ST_WCYC)
      begin
        sda_oe_out <= 1'h0;
        busy_out <= 1'h1;
        if (wcnt_reg == {CNT_BITS{1'b0}})
        begin
          state_reg <= ST_IDLE;
          busy_out <= 1'h0;
          page_mask_reg <= {PAGE_BUF{1'b0}};
          addr_reg <= page_next(last_addr_reg);
        end
        else if (write_done_early_in)
          wcnt_reg <= {CNT_BITS{1'b0}};
        else
          wcnt_reg <= wcnt_reg - {{(CNT_BITS-1){1'b0}}, 1'b1};
      end
      else if (stop_ev)
      begin
        sda_oe_out <= 1'h0;
        if (state_reg == ST_WDATA && bit_reg == 4'h0 && data_seen_reg
          && page_mask_reg != {PAGE_BUF{1'b0}})
        begin
          state_reg <= ST_WCYC;
          busy_out <= 1'h1;
          wcnt_reg <= WRITE_CYCLES[CNT_BITS-1:0];
        end
        else
          state_reg <= ST_IDLE;
      end
      else if (start_ev)
      begin
        state_reg <= ST_SEL;
        bit_reg <= `SLOT_PRE_START;
        sda_oe_out <= 1'h0;
        page_mask_reg <= {PAGE_BUF{1'b0}};
        data_seen_reg <= 1'h0;
      end
      else if (state_reg != ST_IDLE)
      begin
        if (scl_rise)
        begin
          if (bit_reg < `SLOT_ACK)
          begin
            if (state_reg != ST_RDATA)
              shift_reg <= {shift_reg[6:0], sda_reg};
          end
          else if (state_reg == ST_RDATA && sda_reg)
            state_reg <= ST_IDLE;
        end
        else if (scl_fall)
        begin
          sda_oe_out <= 1'h0;
          if (bit_reg == `SLOT_LAST_DATA && state_reg != ST_RDATA)
          begin
            bit_reg <= `SLOT_ACK;
            case (state_reg)
              ST_SEL:
              begin
                ack_ok_reg <= sel_match(shift_reg, ce_reg);
                rd_dir_reg <= shift_reg[0] == `SEL_DIR_READ;
                sda_oe_out <= sel_match(shift_reg, ce_reg);
              end
              ST_ADDR:
              begin
                addr_reg <= shift_reg[ADDR_BITS-1:0];
                sda_oe_out <= 1'h1;
              end
              ST_WDATA:
              begin
                data_seen_reg <= 1'h1;
                if (!wi_reg)
                begin
                  sda_oe_out <= 1'h1;
                  page_data_reg[addr_reg[`PAGE_BITS-1:0]] <= shift_reg;
                  page_mask_reg[addr_reg[`PAGE_BITS-1:0]] <= 1'h1;
                  last_addr_reg <= addr_reg;
                  addr_reg <= page_next(addr_reg);
                end
              end
              default:
                sda_oe_out <= 1'h0;
            endcase
          end
          else if (bit_reg == `SLOT_ACK)
          begin
            bit_reg <= 4'h0;
            if (state_reg == ST_SEL && !ack_ok_reg)
              state_reg <= ST_IDLE;
            else if (state_reg == ST_SEL && rd_dir_reg)
            begin
              state_reg <= ST_RDATA;
              shift_reg <= mem_reg[addr_reg];
              addr_reg <= addr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
              sda_oe_out <= ~mem_reg[addr_reg][`BYTE_MSB];
            end
            else if (state_reg == ST_SEL)
              state_reg <= ST_ADDR;
            else if (state_reg == ST_ADDR)
              state_reg <= ST_WDATA;
            else if (state_reg == ST_RDATA)
            begin
              shift_reg <= mem_reg[addr_reg];
              addr_reg <= addr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
              sda_oe_out <= ~mem_reg[addr_reg][`BYTE_MSB];
            end
          end
          else
          begin
            bit_reg <= bit_reg + 4'h1;
            if (state_reg == ST_RDATA)
            begin
              if (bit_reg == `SLOT_LAST_DATA)
                bit_reg <= `SLOT_ACK;
              else
                sda_oe_out <= ~shift_reg[`BYTE_MSB - 3'h1 - bit_reg[2:0]];
            end
          end
        end
        else if (state_reg == ST_RDATA && bit_reg < `SLOT_ACK)
          sda_oe_out <= sda_oe_out;
      end
    end
  end

endmodule // i2c_eeprom_slave
`default_nettype wire

// ===== verif/eeprom_monitor.sv
// assertions on the eeprom target ports
// assumes bind onto i2c_eeprom_slave, one clock domain
`timescale 1ns/1ps
`default_nettype none
module eeprom_monitor #(
  parameter int WRITE_CYCLES = 500000
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic write_done_early_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic busy_out
);
  // ****************
  // busy length count
  // ****************
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  always @*
    cnt_next = busy_out ? cnt_reg + 32'h1 : 32'h0;
  always @(posedge mclk_in or negedge rstn_in)
    if (!rstn_in)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_next;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  property p_od;
    sda_oe_out |-> !sda_out;
  endproperty
  a_od: assert property (p_od)
    else $error("sda driven high");
  property p_quiet;
    busy_out |-> !sda_oe_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("oe high while busy");
  property p_rise;
    $rose(sda_oe_out) |-> !scl_in && !busy_out;
  endproperty
  a_rise: assert property (p_rise)
    else $error("oe rose while scl high");
  property p_fall;
    $fell(sda_oe_out) |-> !scl_in;
  endproperty
  a_fall: assert property (p_fall)
    else $error("oe fell while scl high");
  property p_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe_out);
  endproperty
  a_high: assert property (p_high)
    else $error("oe moved in scl high");
  property p_stand;
    $rose(sda_oe_out) |=> sda_oe_out [*8];
  endproperty
  a_stand: assert property (p_stand)
    else $error("oe pulse too short");
  property p_stop;
    $rose(busy_out) |-> scl_in && sda_in;
  endproperty
  a_stop: assert property (p_stop)
    else $error("busy without stop");
  property p_early;
    busy_out && write_done_early_in |-> ##[1:2] !busy_out;
  endproperty
  a_early: assert property (p_early)
    else $error("early end ignored");
  property p_len;
    $fell(busy_out) && !$past(write_done_early_in)
      && !$past(write_done_early_in, 2)
      |-> cnt_reg + 1 >= WRITE_CYCLES && cnt_reg <= WRITE_CYCLES + 1;
  endproperty
  a_len: assert property (p_len)
    else $error("write cycle length wrong");
endmodule // eeprom_monitor
bind i2c_eeprom_slave eeprom_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES)
) mon_u (
  .mclk_in(mclk_in),
  .rstn_in(rstn_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .write_done_early_in(write_done_early_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .busy_out(busy_out)
);
`default_nettype wire

// ===== verif/i2c_master_model.sv
// bus master model driving scl and sda
// assumes pull-up wired-and sda outside; 1 means released
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int H = 20
) (
  input wire logic mclk_in,
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task wt();
    repeat (H) @(posedge mclk_in);
    #1;
  endtask
  task start();
    sda_out = 1'b1;
    wt();
    scl_out = 1'b1;
    wt();
    sda_out = 1'b0;
    wt();
    scl_out = 1'b0;
    wt();
  endtask
  task stop();
    sda_out = 1'b0;
    wt();
    scl_out = 1'b1;
    wt();
    sda_out = 1'b1;
    wt();
  endtask
  task bit_x(input logic b, output logic r);
    sda_out = b;
    wt();
    scl_out = 1'b1;
    wt();
    r = sda_in;
    scl_out = 1'b0;
    wt();
  endtask
  task xfer(input logic [7:0] d, input logic ab,
    output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ab, a);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the eeprom target
// assumes monitor bound to the design; master model instantiated here
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defs.vh"
module tb_top;
  localparam int WC = 3000;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] ce = 3'h0;
  logic inh = 1'b0;
  logic early = 1'b0;
  logic [7:0] q;
  logic a;
  logic [7:0] mem [256];
  int cur = 0;
  int failures = 0;
  int checks_done = 0;
  wire logic m_scl, m_sda, d_sda, d_oe, busy;
  wire logic sda_w = m_sda & (d_oe ? d_sda : 1'b1);
  always #5 mclk_in = ~mclk_in;
  i2c_eeprom_slave #(.WRITE_CYCLES(WC)) dut_u (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .scl_in(m_scl),
    .sda_in(sda_w),
    .chip_sel_bit2_in(ce[2]),
    .chip_sel_bit1_in(ce[1]),
    .chip_sel_bit0_in(ce[0]),
    .write_inhibit_pin_in(inh),
    .write_done_early_in(early),
    .sda_out(d_sda),
    .sda_oe_out(d_oe),
    .busy_out(busy)
  );
  i2c_master_model mst_u (
    .mclk_in(mclk_in),
    .sda_in(sda_w),
    .scl_out(m_scl),
    .sda_out(m_sda)
  );
  task complete_run();
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task sel(input logic [2:0] c, input logic d);
    mst_u.start();
    mst_u.xfer({`SEL_TYPE_ID, c, d}, 1'b1, q, a);
  endtask
  task seek(input logic [7:0] ad);
    sel(ce, 1'b0);
    chk("sack", 8'h00, {7'h00, a});
    mst_u.xfer(ad, 1'b1, q, a);
    chk("aack", 8'h00, {7'h00, a});
    cur = ad;
  endtask
  task rd(input logic last);
    mst_u.xfer(8'hFF, last, q, a);
    chk("rd", mem[cur], q);
    cur = (cur + 1) % 256;
  endtask
  task rd_at(input logic [7:0] ad);
    seek(ad);
    sel(ce, 1'b1);
    rd(1'b1);
    mst_u.stop();
  endtask
  task busy_is(input logic e);
    chk("busy", {7'h00, e}, {7'h00, busy});
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    failures++;
    complete_run();
  end
  initial
  begin
    logic [7:0] b, d;
    int i;
    void'($urandom(17));
    foreach (mem[k]) mem[k] = 8'hFF;
    repeat (3) @(posedge mclk_in);
    #1;
    rstn_in = 1'b1;
    ce = 3'($urandom);
    repeat (10) @(posedge mclk_in);
    #1;
    sel(ce, 1'b1);
    chk("ack", 8'h00, {7'h00, a});
    rd(1'b1);
    mst_u.stop();
    sel(ce ^ 3'(1 + $urandom % 7), 1'b1);
    chk("nak", 8'h01, {7'h00, a});
    mst_u.stop();
    b = 8'($urandom) | 8'h01;
    seek(b);
    for (i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      mst_u.xfer(d, 1'b1, q, a);
      chk("wack", 8'h00, {7'h00, a});
      mem[{b[7:4], 4'(b[3:0] + i)}] = d;
    end
    mst_u.stop();
    cur = b;
    busy_is(1'b1);
    sel(ce, 1'b1);
    chk("poll", 8'h01, {7'h00, a});
    mst_u.stop();
    for (i = 0; i < WC + 50 && busy !== 1'b0; i++)
      @(posedge mclk_in);
    #1;
    busy_is(1'b0);
    sel(ce, 1'b1);
    rd(1'b0);
    rd(1'b1);
    mst_u.stop();
    seek(8'hFE);
    sel(ce, 1'b1);
    for (i = 0; i < 4; i++)
      rd(i == 3);
    mst_u.stop();
    inh = 1'b1;
    b = 8'($urandom);
    seek(b);
    mst_u.xfer(~mem[b], 1'b1, q, a);
    chk("inak", 8'h01, {7'h00, a});
    mst_u.stop();
    busy_is(1'b0);
    rd_at(b);
    inh = 1'b0;
    seek(8'h10);
    mst_u.stop();
    busy_is(1'b0);
    b = 8'($urandom);
    d = 8'($urandom);
    seek(b);
    mst_u.xfer(d, 1'b1, q, a);
    mem[b] = d;
    mst_u.stop();
    early = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    busy_is(1'b0);
    early = 1'b0;
    rd_at(b);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
